// *** cop_defines.vh ***
`ifndef COP_DEFINES_VH
`define COP_DEFINES_VH
// Register commands
`define COP_CMD_OPT_ONE 8'h30
`define COP_CMD_OPT_TWO 8'h31
// Reset values
`define COP_OPT_ONE_RST 16'h0011
`define COP_OPT_TWO_RST 16'h02B7
// Option one fields
`define COP_F_PATH_OFF 3
`define COP_F_SHIP 1
`define COP_F_WAKE 0
// Option two fields
`define COP_F_OVLD_HI 15
`define COP_F_OVLD_LO 14
`define COP_F_CUR_EN 13
`define COP_F_SAG_EN 12
`define COP_F_OVLD_FLAG 11
`define COP_F_RELAX_FLAG 10
`define COP_F_PER_HI 9
`define COP_F_PER_LO 8
// Times
`define COP_CLK_HZ 125000000
`define COP_SHIP_MS 140
`define COP_WAKE_MIN 30
`define COP_OCP_BLANK_US 100
`define COP_WAKE_MA 8'h80
`define COP_MS_PER_MIN 60000
// Overload time per duration code, in ms
`define COP_OVLD_MS_00 6'h01
`define COP_OVLD_MS_01 6'h02
`define COP_OVLD_MS_10 6'h0A
`define COP_OVLD_MS_11 6'h14
// Cycle period per period code, in ms
`define COP_PER_MS_00 6'h05
`define COP_PER_MS_01 6'h0A
`define COP_PER_MS_10 6'h14
`define COP_PER_MS_11 6'h28
`define COP_MS_CYCLES (`COP_CLK_HZ / 1000)
`define COP_US_CYCLES (`COP_CLK_HZ / 1000000)
`endif

// *** cop_host.sv ***
module cop_host (
   input wire ref_clk,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regCmd,
   output logic [15:0] regWdata,
   input wire [15:0] regRdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regCmd = 8'h00;
      regWdata = 16'h0000;
   end
   // Strobe held to the taking edge, command and data scrambled after
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge ref_clk);
      #1;
      regCmd = c;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge ref_clk);
      #1;
      regWrite = 1'b0;
      regCmd = ~c;
      regWdata = ~d;
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(posedge ref_clk);
      #1;
      regCmd = c;
      regRead = 1'b1;
      @(posedge ref_clk);
      #1;
      regRead = 1'b0;
      regCmd = ~c;
      @(posedge ref_clk);
      #1;
      d = regRdata;
   endtask
endmodule // cop_host

// *** cop_ms_tick.v ***
`include "cop_defines.vh"
module cop_ms_tick #(
   parameter integer DIV = `COP_MS_CYCLES
) (
   ref_clk,
   reset,
   tick
);
   input wire ref_clk;
   input wire reset;
   output reg tick;
   reg [31:0] cnt_reg;
   // One-cycle enable each DIV clocks
   always @(posedge ref_clk) begin
      if (reset) begin
         cnt_reg <= 32'h00000000;
         tick <= 1'b0;
      end else if (cnt_reg >= DIV - 1) begin
         cnt_reg <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule // cop_ms_tick

// *** cop_option_regs.v ***
`include "cop_defines.vh"
module cop_option_regs #(
   parameter integer MS_DIV = `COP_MS_CYCLES,
   parameter integer SHIP_MS = `COP_SHIP_MS,
   parameter integer WAKE_MS = `COP_WAKE_MIN * `COP_MS_PER_MIN,
   parameter integer BLANK_CYC = `COP_OCP_BLANK_US * `COP_US_CYCLES
) (
   ref_clk,
   reset,
   regWrite,
   regRead,
   regCmd,
   regWdata,
   regRdata,
   comparatorTrip,
   inputOvercurrentTrip,
   inputOcpEn,
   batteryBelowMin,
   adapterPresent,
   currentOvershoot,
   railSag,
   converterEnable,
   supplyGoodOut,
   batterySenseDischarge,
   wakeChargeEn,
   wakeChargeMa,
   overloadActive,
   relaxActive
);
   input wire ref_clk;
   input wire reset;
   input wire regWrite;
   input wire regRead;
   input wire [7:0] regCmd;
   input wire [15:0] regWdata;
   output reg [15:0] regRdata;
   input wire comparatorTrip;
   input wire inputOvercurrentTrip;
   input wire inputOcpEn;
   input wire batteryBelowMin;
   input wire adapterPresent;
   input wire currentOvershoot;
   input wire railSag;
   output reg converterEnable;
   output reg supplyGoodOut;
   output reg batterySenseDischarge;
   output reg wakeChargeEn;
   output wire [7:0] wakeChargeMa;
   output wire overloadActive;
   output wire relaxActive;

   localparam [2:0] PK_IDLE = 3'h1, PK_OVLD = 3'h2, PK_RELAX = 3'h4;

   // Pin synchronisers
   reg [6:0] sync1Reg, sync2Reg;
   always @(posedge ref_clk) begin
      if (reset) begin
         sync1Reg <= 7'h00;
         sync2Reg <= 7'h00;
      end else begin
         sync1Reg <= {comparatorTrip, inputOvercurrentTrip, inputOcpEn, batteryBelowMin,
            adapterPresent, currentOvershoot, railSag};
         sync2Reg <= sync1Reg;
      end
   end
   wire cmpS = sync2Reg[6];
   wire ocS = sync2Reg[5];
   wire ocEnS = sync2Reg[4];
   wire lowBatS = sync2Reg[3];
   wire adpS = sync2Reg[2];
   wire curS = sync2Reg[1];
   wire sagS = sync2Reg[0];

   wire msTick;
   cop_ms_tick #(.DIV(MS_DIV)) uTick (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(msTick)
   );

   reg [15:0] optOne_reg;
   reg [15:0] optTwo_reg;
   reg [2:0] pkState_reg;
   reg [15:0] shipCnt_reg;
   reg [31:0] wakeCnt_reg;
   reg [31:0] blankCnt_reg;
   reg [5:0] phaseCnt_reg;
   reg wakeDone_reg;
   reg ocLatched_reg;

   wire wrOne = regWrite && (regCmd == `COP_CMD_OPT_ONE);
   wire wrTwo = regWrite && (regCmd == `COP_CMD_OPT_TWO);
   wire [1:0] ovSel = optTwo_reg[`COP_F_OVLD_HI:`COP_F_OVLD_LO];
   wire [1:0] perSel = optTwo_reg[`COP_F_PER_HI:`COP_F_PER_LO];
   reg [5:0] ovMs, perMs;
   always @* begin
      case (ovSel)
         2'h0: ovMs = `COP_OVLD_MS_00;
         2'h1: ovMs = `COP_OVLD_MS_01;
         2'h2: ovMs = `COP_OVLD_MS_10;
         default: ovMs = `COP_OVLD_MS_11;
      endcase
      case (perSel)
         2'h0: perMs = `COP_PER_MS_00;
         2'h1: perMs = `COP_PER_MS_01;
         2'h2: perMs = `COP_PER_MS_10;
         default: perMs = `COP_PER_MS_11;
      endcase
   end
   wire noRelax = ovMs >= perMs;
   wire pkEnabled = optTwo_reg[`COP_F_CUR_EN] | optTwo_reg[`COP_F_SAG_EN];
   wire pkTrigger = (optTwo_reg[`COP_F_CUR_EN] & curS) | (optTwo_reg[`COP_F_SAG_EN] & sagS);
   wire hostExitOvld = wrTwo && !regWdata[`COP_F_OVLD_FLAG];
   wire hostExitRelax = wrTwo && !regWdata[`COP_F_RELAX_FLAG];

   // Peak power phase machine
   always @(posedge ref_clk) begin
      if (reset) begin
         pkState_reg <= PK_IDLE;
         phaseCnt_reg <= 6'h00;
      end else begin
         case (pkState_reg)
            PK_IDLE: begin
               phaseCnt_reg <= 6'h00;
               if (pkEnabled && pkTrigger && adpS)
                  pkState_reg <= PK_OVLD;
            end
            PK_OVLD: begin
               if (!pkEnabled || hostExitOvld) begin
                  pkState_reg <= PK_IDLE;
               end else if (msTick) begin
                  if (phaseCnt_reg + 6'h01 >= ovMs) begin
                     phaseCnt_reg <= 6'h00;
                     pkState_reg <= noRelax ? PK_IDLE : PK_RELAX;
                  end else
                     phaseCnt_reg <= phaseCnt_reg + 6'h01;
               end
            end
            PK_RELAX: begin
               if (!pkEnabled || hostExitRelax) begin
                  pkState_reg <= PK_IDLE;
                  phaseCnt_reg <= 6'h00;
               end else if (msTick) begin
                  if (phaseCnt_reg + 6'h01 >= perMs - ovMs) begin
                     phaseCnt_reg <= 6'h00;
                     pkState_reg <= pkTrigger ? PK_OVLD : PK_IDLE;
                  end else
                     phaseCnt_reg <= phaseCnt_reg + 6'h01;
               end
            end
            default: pkState_reg <= PK_IDLE;
         endcase
      end
   end
   assign overloadActive = (pkState_reg == PK_OVLD);
   assign relaxActive = (pkState_reg == PK_RELAX);

   // Option registers
   wire shipDone = optOne_reg[`COP_F_SHIP] && msTick && (shipCnt_reg + 16'h0001 >= SHIP_MS);
   wire wakeEnd = optOne_reg[`COP_F_WAKE] && wakeChargeEn && !lowBatS;
   always @(posedge ref_clk) begin
      if (reset) begin
         optOne_reg <= `COP_OPT_ONE_RST;
         optTwo_reg <= `COP_OPT_TWO_RST;
      end else begin
         if (wrOne)
            optOne_reg <= regWdata;
         else begin
            if (shipDone)
               optOne_reg[`COP_F_SHIP] <= 1'b0;
            if (wakeEnd)
               optOne_reg[`COP_F_WAKE] <= 1'b0;
         end
         if (wrTwo)
            optTwo_reg <= regWdata;
         if (!adpS) begin
            optTwo_reg[`COP_F_CUR_EN] <= 1'b0;
            optTwo_reg[`COP_F_SAG_EN] <= 1'b0;
         end
      end
   end

   // Ship discharge timer
   always @(posedge ref_clk) begin
      if (reset) begin
         shipCnt_reg <= 16'h0000;
         batterySenseDischarge <= 1'b0;
      end else begin
         batterySenseDischarge <= optOne_reg[`COP_F_SHIP] && !shipDone;
         if (!optOne_reg[`COP_F_SHIP] || shipDone)
            shipCnt_reg <= 16'h0000;
         else if (msTick)
            shipCnt_reg <= shipCnt_reg + 16'h0001;
      end
   end

   // Auto wakeup charge
   always @(posedge ref_clk) begin
      if (reset) begin
         wakeChargeEn <= 1'b0;
         wakeCnt_reg <= 32'h00000000;
         wakeDone_reg <= 1'b0;
      end else begin
         if (!optOne_reg[`COP_F_WAKE] || !lowBatS) begin
            wakeChargeEn <= 1'b0;
            wakeCnt_reg <= 32'h00000000;
            wakeDone_reg <= 1'b0;
         end else if (!wakeDone_reg) begin
            wakeChargeEn <= 1'b1;
            if (msTick) begin
               if (wakeCnt_reg + 32'h00000001 >= WAKE_MS) begin
                  wakeDone_reg <= 1'b1;
                  wakeChargeEn <= 1'b0;
               end else
                  wakeCnt_reg <= wakeCnt_reg + 32'h00000001;
            end
         end
      end
   end
   assign wakeChargeMa = wakeChargeEn ? `COP_WAKE_MA : 8'h00;

   // Overcurrent blanking and converter control
   always @(posedge ref_clk) begin
      if (reset) begin
         blankCnt_reg <= 32'h00000000;
         ocLatched_reg <= 1'b0;
      end else if (!(ocEnS && ocS)) begin
         blankCnt_reg <= 32'h00000000;
      end else if (blankCnt_reg + 32'h00000001 >= BLANK_CYC) begin
         ocLatched_reg <= 1'b1;
      end else
         blankCnt_reg <= blankCnt_reg + 32'h00000001;
   end
   wire pathOff = optOne_reg[`COP_F_PATH_OFF] && cmpS;
   always @(posedge ref_clk) begin
      if (reset) begin
         converterEnable <= 1'b0;
         supplyGoodOut <= 1'b0;
      end else begin
         converterEnable <= adpS && !pathOff && !ocLatched_reg;
         supplyGoodOut <= adpS && !pathOff;
      end
   end

   // Readback with live phase flags
   always @(posedge ref_clk) begin
      if (reset)
         regRdata <= 16'h0000;
      else if (regRead) begin
         if (regCmd == `COP_CMD_OPT_ONE)
            regRdata <= optOne_reg;
         else if (regCmd == `COP_CMD_OPT_TWO) begin
            regRdata <= optTwo_reg;
            regRdata[`COP_F_OVLD_FLAG] <= overloadActive;
            regRdata[`COP_F_RELAX_FLAG] <= relaxActive;
         end else
            regRdata <= 16'h0000;
      end
   end
endmodule // cop_option_regs

// *** cop_option_regs_properties.sv ***
module cop_checker #(
   parameter integer MS_DIV = 10,
   parameter integer SHIP_MS = 140,
   parameter integer WAKE_MS = 50,
   parameter integer BLANK_CYC = 5
) (
   input wire ref_clk,
   input wire reset,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regCmd,
   input wire [15:0] regWdata,
   input wire [15:0] regRdata,
   input wire comparatorTrip,
   input wire inputOvercurrentTrip,
   input wire inputOcpEn,
   input wire batteryBelowMin,
   input wire adapterPresent,
   input wire converterEnable,
   input wire supplyGoodOut,
   input wire batterySenseDischarge,
   input wire wakeChargeEn,
   input wire [7:0] wakeChargeMa,
   input wire overloadActive,
   input wire relaxActive
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pathOff_reg = 1'b0;
   int shipCnt_reg = 0;
   int wakeCnt_reg = 0;
   int ocpCnt_reg = 0;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // Shadow of the path-off bit and run-length counters
   always @(posedge ref_clk) begin
      if (reset) pathOff_reg <= 1'b0;
      else if (regWrite && regCmd == 8'h30) pathOff_reg <= regWdata[3];
      shipCnt_reg <= batterySenseDischarge ? shipCnt_reg + 1 : 0;
      wakeCnt_reg <= wakeChargeEn ? wakeCnt_reg + 1 : 0;
      ocpCnt_reg <= (inputOcpEn && inputOvercurrentTrip) ? ocpCnt_reg + 1 : 0;
   end
   chk_path_off: assert property (
      (pathOff_reg && comparatorTrip && adapterPresent) [*5] |-> !supplyGoodOut && !converterEnable)
      else $error("path off ignored");
   chk_supply_good: assert property (
      (adapterPresent && !comparatorTrip) [*5] |-> supplyGoodOut) else $error("supply good low");
   chk_ship_start: assert property (
      regWrite && regCmd == 8'h30 && regWdata[1] |-> ##[1:3] batterySenseDischarge) else $error("no discharge");
   chk_ship_len: assert property (
      shipCnt_reg <= SHIP_MS * MS_DIV + MS_DIV) else $error("discharge too long");
   chk_wake_current: assert property (
      wakeChargeMa == (wakeChargeEn ? 8'h80 : 8'h00)) else $error("wake current wrong");
   chk_wake_len: assert property (
      wakeCnt_reg <= WAKE_MS * MS_DIV + MS_DIV) else $error("wake charge too long");
   chk_wake_end: assert property (
      !batteryBelowMin [*5] |-> !wakeChargeEn) else $error("wake charge not ended");
   chk_peak_adapter: assert property (
      !adapterPresent [*5] |-> !overloadActive && !relaxActive) else $error("peak without adapter");
   chk_phase_excl: assert property (
      !(overloadActive && relaxActive)) else $error("both phases");
   chk_ovld_exit: assert property (
      regWrite && regCmd == 8'h31 && !regWdata[11] && overloadActive |-> ##[1:2] !overloadActive)
      else $error("overload not exited");
   chk_relax_exit: assert property (
      regWrite && regCmd == 8'h31 && !regWdata[10] && relaxActive |-> ##[1:2] !relaxActive)
      else $error("relax not exited");
   chk_unmapped_read: assert property (
      regRead && regCmd != 8'h30 && regCmd != 8'h31 |=> regRdata == 16'h0000) else $error("unmapped data");
   chk_ocp_off: assert property (
      ocpCnt_reg > BLANK_CYC + 5 |-> !converterEnable) else $error("overcurrent ignored");
   cover property ($rose(overloadActive));
   cover property ($rose(relaxActive));
   cover property ($fell(batterySenseDischarge));
endmodule // cop_checker

bind cop_option_regs cop_checker #(.MS_DIV(MS_DIV), .SHIP_MS(SHIP_MS), .WAKE_MS(WAKE_MS), .BLANK_CYC(BLANK_CYC)) chk (
   .ref_clk(ref_clk), .reset(reset), .regWrite(regWrite), .regRead(regRead), .regCmd(regCmd),
   .regWdata(regWdata), .regRdata(regRdata), .comparatorTrip(comparatorTrip),
   .inputOvercurrentTrip(inputOvercurrentTrip), .inputOcpEn(inputOcpEn), .batteryBelowMin(batteryBelowMin),
   .adapterPresent(adapterPresent), .converterEnable(converterEnable), .supplyGoodOut(supplyGoodOut),
   .batterySenseDischarge(batterySenseDischarge), .wakeChargeEn(wakeChargeEn), .wakeChargeMa(wakeChargeMa),
   .overloadActive(overloadActive), .relaxActive(relaxActive));

// *** tb.sv ***
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam integer MSD = 10;
   logic ref_clk = 1'b0, reset = 1'b1, cmp = 1'b0, oc = 1'b0, ocpEn = 1'b0, bLow = 1'b0;
   logic adp = 1'b1, ovs = 1'b0, sag = 1'b0;
   logic [15:0] q;
   wire regWrite, regRead, conv, good, ship, wEn, ovl, rlx;
   wire [7:0] regCmd, wMa;
   wire [15:0] regWdata, regRdata;
   int error_cnt = 0, n_compared = 0, k, n1, n2;
   cop_host host (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead), .regCmd(regCmd),
      .regWdata(regWdata), .regRdata(regRdata));
   cop_option_regs #(.MS_DIV(MSD), .SHIP_MS(140), .WAKE_MS(50), .BLANK_CYC(5)) dut (
      .ref_clk(ref_clk), .reset(reset), .regWrite(regWrite), .regRead(regRead), .regCmd(regCmd),
      .regWdata(regWdata), .regRdata(regRdata), .comparatorTrip(cmp), .inputOvercurrentTrip(oc),
      .inputOcpEn(ocpEn), .batteryBelowMin(bLow), .adapterPresent(adp), .currentOvershoot(ovs),
      .railSag(sag), .converterEnable(conv), .supplyGoodOut(good), .batterySenseDischarge(ship),
      .wakeChargeEn(wEn), .wakeChargeMa(wMa), .overloadActive(ovl), .relaxActive(rlx));
   initial forever #4 ref_clk = ~ref_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   function automatic logic near(input int a, input int b);
      return (a >= b - MSD) && (a <= b + MSD);
   endfunction
   task automatic conclude;
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Overload length and relax length of one period
   task automatic peak(input logic [1:0] d, input logic [1:0] p);
      int od, pd;
      od = d == 2'h0 ? 1 : d == 2'h1 ? 2 : d == 2'h2 ? 10 : 20;
      pd = 5 << p;
      host.wr(8'h31, {d, 4'h8, p, 8'hB7});
      ovs = 1'b1;
      for (k = 0; k < 40 && ovl !== 1'b1; k++) tick(1);
      host.rd(8'h31, q);
      `CHK(q, {d, 4'hA, p, 8'hB7});
      for (n1 = 3; ovl === 1'b1 && n1 < 1000; n1++) tick(1);
      for (n2 = 0, k = 0; ovl !== 1'b1 && k < 1000; k++) begin
         n2 += (rlx === 1'b1);
         tick(1);
      end
      `CHK(near(n1, od * MSD), 1'b1);
      `CHK(near(n2, pd > od ? (pd - od) * MSD : 0), 1'b1);
      ovs = 1'b0;
      host.wr(8'h31, 16'h0000);
      tick(3);
   endtask
   initial begin
      #400000;
      error_cnt++;
      conclude;
   end
   initial begin
      tick(10);
      reset = 1'b0;
      host.rd(8'h31, q);
      `CHK(q, 16'h02B7);
      host.rd(8'h30, q);
      `CHK(q, 16'h0011);
      host.rd(8'h32, q);
      `CHK(q, 16'h0000);
      host.wr(8'h31, 16'h3000);
      host.rd(8'h31, q);
      `CHK(q, 16'h3000);
      adp = 1'b0;
      tick(5);
      host.rd(8'h31, q);
      `CHK(q, 16'h0000);
      adp = 1'b1;
      tick(5);
      for (int i = 0; i < 4; i++) peak(i[1:0], i[1:0]);
      peak(2'h3, 2'h0);
      host.wr(8'h31, 16'h1300);
      sag = 1'b1;
      for (k = 0; k < 40 && ovl !== 1'b1; k++) tick(1);
      `CHK(ovl, 1'b1);
      host.wr(8'h31, 16'h1300);
      `CHK(ovl, 1'b0);
      for (k = 0; k < 900 && rlx !== 1'b1; k++) tick(1);
      host.wr(8'h31, 16'h1300);
      tick(1);
      `CHK(rlx, 1'b0);
      host.wr(8'h31, 16'h0200);
      ovs = 1'b1;
      tick(20);
      `CHK({ovl, rlx}, 2'b00);
      ovs = 1'b0;
      sag = 1'b0;
      cmp = 1'b1;
      tick(5);
      `CHK({good, conv}, 2'b11);
      host.wr(8'h30, 16'h0019);
      tick(5);
      `CHK({good, conv}, 2'b00);
      cmp = 1'b0;
      tick(5);
      `CHK({good, conv}, 2'b11);
      host.wr(8'h30, 16'h0013);
      tick(1);
      `CHK(ship, 1'b1);
      tick(140 * MSD - 20);
      `CHK(ship, 1'b1);
      tick(40);
      `CHK(ship, 1'b0);
      host.rd(8'h30, q);
      `CHK(q[1], 1'b0);
      bLow = 1'b1;
      tick(5);
      `CHK({wEn, wMa}, 9'h180);
      bLow = 1'b0;
      tick(5);
      host.rd(8'h30, q);
      `CHK({wEn, q[0]}, 2'b00);
      host.wr(8'h30, 16'h0011);
      bLow = 1'b1;
      tick(50 * MSD - 20);
      `CHK(wEn, 1'b1);
      tick(40);
      `CHK(wEn, 1'b0);
      bLow = 1'b0;
      ocpEn = 1'b1;
      oc = 1'b1;
      tick(3);
      oc = 1'b0;
      tick(5);
      `CHK(conv, 1'b1);
      oc = 1'b1;
      tick(12);
      oc = 1'b0;
      tick(3);
      `CHK(conv, 1'b0);
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      tick(6);
      `CHK(conv, 1'b1);
      conclude;
   end
endmodule // tb
